// [hdl/cts_thermal_regs.svh]
// Register bit positions, masks and reset values of the thermal block
`ifndef CTS_THERMAL_REGS_SVH
`define CTS_THERMAL_REGS_SVH

// Thermal status register
`define CTS_ST_HOT        0
`define CTS_ST_HOT_LOG    1
`define CTS_ST_EXT        2
`define CTS_ST_EXT_LOG    3
`define CTS_ST_CRIT       4
`define CTS_ST_CRIT_LOG   5
`define CTS_ST_THR1       6
`define CTS_ST_THR1_LOG   7
`define CTS_ST_THR2       8
`define CTS_ST_THR2_LOG   9
`define CTS_ST_PLIM       10
`define CTS_ST_PLIM_LOG   11
`define CTS_ST_RDOUT_LSB  16
`define CTS_ST_RDOUT_MSB  22
`define CTS_ST_RES_LSB    27
`define CTS_ST_RES_MSB    30
`define CTS_ST_VALID      31

// Thermal interrupt control register
`define CTS_CTL_HI_EN     0
`define CTS_CTL_LO_EN     1
`define CTS_CTL_EXT_EN    2
`define CTS_CTL_FPR_EN    3
`define CTS_CTL_CRIT_EN   4
`define CTS_CTL_THR1_LSB  8
`define CTS_CTL_THR1_MSB  14
`define CTS_CTL_THR1_EN   15
`define CTS_CTL_THR2_LSB  16
`define CTS_CTL_THR2_MSB  22
`define CTS_CTL_THR2_EN   23
`define CTS_CTL_PLN_EN    24
`define CTS_CTL_WMASK     64'h0000_0000_01FF_FF1F
`define CTS_CTL_RESET     64'h0000_0000_0000_0000

// Sticky log group
`define CTS_LOG_N         6
`define CTS_LOG_RESET     6'h00
`define CTS_RES_DEFAULT   4'h1

`endif

// [hdl/cts_pkg.sv]
// Types shared by the thermal status and alert block
package cts_pkg;

  typedef struct packed {
    logic       hot;        // Internal hot-temperature detector
    logic       crit;       // Critical-temperature detector
    logic       ext_hot_n;  // External hot pin, low when asserted
    logic       fpr_n;      // force_power_reduction_pin, low when asserted
    logic       bidir_en;   // Bidirectional hot-pin feature enable
    logic       below_req;  // Core below requested perf state or duty
    logic       valid;      // Sensor readout valid
    logic [6:0] readout;    // Degrees below throttle_activation_point
  } cts_sensor_t;

  typedef struct packed {
    logic       status_wr;  // Write strobe, thermal status register
    logic       ctl_wr;     // Write strobe, interrupt control register
    logic [63:0] wdata;
  } cts_msr_wr_t;

  typedef struct packed {
    logic [5:0] log;
  } cts_log_state_t;

  typedef struct packed {
    logic at_or_above;
  } cts_thr_state_t;

  typedef struct packed {
    logic       hot;
    logic       ext;
    logic       crit;
    logic       plim;
    logic       valid;
    logic [6:0] readout;
    logic [63:0] ctl;
    logic       irq;
    logic       pnote;
    logic [7:0] cause;
    logic       ext_ack;    // Previous acknowledged external hot pin level
    logic       fpr;        // Previous force pin level
  } cts_main_state_t;

endpackage : cts_pkg

// [hdl/cts_sticky_log.sv]
// Sticky log bits: set by hardware, cleared by a write of zero
`timescale 1ns/100ps
`default_nettype none

module cts_sticky_log
  import cts_pkg::*;
#(
  parameter int N = 6
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] log_o
);

  logic [N-1:0] st;
  logic [N-1:0] next_st;

  // Set beats a clear in the same cycle so no event is lost
  for (genvar k = 0; k < N; k++) begin : g_bit
    assign next_st[k] = set_i[k] | (st[k] & ~clr_i[k]);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign log_o = st;

endmodule : cts_sticky_log

`default_nettype wire

// [hdl/cts_thr_cmp.sv]
// One temperature threshold: compare and crossing detect
`timescale 1ns/100ps
`default_nettype none

module cts_thr_cmp
  import cts_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         valid_i,
  input  wire logic [W-1:0] readout_i,
  input  wire logic [W-1:0] thr_i,
  output logic              reached_o,
  output logic              at_or_above_o,
  output logic              cross_o
);

  cts_thr_state_t st;
  cts_thr_state_t next_st;

  // Lower readout is hotter, so reaching means readout <= threshold
  always_comb begin
    next_st             = st;
    next_st.at_or_above = valid_i && (readout_i <= thr_i);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reached_o     = next_st.at_or_above;
  assign at_or_above_o = st.at_or_above;
  // Either direction counts as a crossing
  assign cross_o       = next_st.at_or_above ^ st.at_or_above;

endmodule : cts_thr_cmp

`default_nettype wire

// [hdl/cts_core_thermal.sv]
// Per-core thermal status, sticky logs and thermal interrupt requests
//
// Functional notes
// - Status bit 0 follows the internal hot detector; writes ignored.
// - Log bit 1 records any hot detector assertion until cleared.
// - Bit 2 is high while the force pin or, with bidir, the external hot pin is asserted.
// - Log bit 3 records external pin assertions; hot pin needs bidir.
// - Bit 4 follows the critical-temperature detector output.
// - Log bit 5 records any critical detector assertion.
// - Bit 6 is high while temperature is at or above threshold one.
// - Log bit 7 records that threshold one was reached.
// - Bit 8 is high while temperature is at or above threshold two.
// - Log bit 9 records that threshold two was reached.
// - Bit 10 is high while core runs below requested perf or duty.
// - Log bit 11 records any drop below requested perf or duty.
// - Bits 22:16 report degrees below the throttle activation point.
// - Bits 30:27 report sensor resolution in whole degrees.
// - Bit 31 is high only while the readout holds a valid value.
// - Enable bits 0 and 1 request irq on hot rise and fall.
// - Enable bit 2 for external hot pin with bidir, bit 3 force pin.
// - Enable bit 4 requests irq on critical detector assertion.
// - Threshold one in bits 14:8; bit 15 enables crossing irq.
// - Threshold two in bits 22:16; bit 23 enables crossing irq.
// - Enable bit 24 raises power notification on perf drop.
`include "cts_thermal_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cts_core_thermal
  import cts_pkg::*;
#(
  parameter logic [3:0] RES_DEG = `CTS_RES_DEFAULT
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire cts_sensor_t  sensor_i,
  input  wire cts_msr_wr_t  msr_wr_i,
  output logic      [63:0]  therm_status_o,
  output logic      [63:0]  therm_irq_ctl_o,
  output logic              thermal_irq_o,
  output logic              power_note_o,
  output logic      [7:0]   irq_cause_o
);

  cts_main_state_t st;
  cts_main_state_t next_st;

  logic       hot_now;
  logic       ext_now;
  logic       ext_hot_ack;
  logic       fpr_now;
  logic       crit_now;
  logic       plim_now;
  logic       fpr_prev;
  logic       ext_hot_prev;
  logic [5:0] log_set;
  logic [5:0] log_clr;
  logic [5:0] log_q;
  logic       thr1_reached;
  logic       thr1_q;
  logic       thr1_cross;
  logic       thr2_reached;
  logic       thr2_q;
  logic       thr2_cross;
  logic [7:0] cause;

  // Pins are active low; the hot pin only counts with the bidir feature
  assign ext_hot_ack = ~sensor_i.ext_hot_n & sensor_i.bidir_en;
  assign fpr_now     = ~sensor_i.fpr_n;
  assign ext_now     = ext_hot_ack | fpr_now;
  assign hot_now     = sensor_i.hot;
  assign crit_now    = sensor_i.crit;
  assign plim_now    = sensor_i.below_req;

  cts_thr_cmp #(
    .W (7)
  ) u_thr1 (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .valid_i       (sensor_i.valid),
    .readout_i     (sensor_i.readout),
    .thr_i         (st.ctl[`CTS_CTL_THR1_MSB:`CTS_CTL_THR1_LSB]),
    .reached_o     (thr1_reached),
    .at_or_above_o (thr1_q),
    .cross_o       (thr1_cross)
  );

  cts_thr_cmp #(
    .W (7)
  ) u_thr2 (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .valid_i       (sensor_i.valid),
    .readout_i     (sensor_i.readout),
    .thr_i         (st.ctl[`CTS_CTL_THR2_MSB:`CTS_CTL_THR2_LSB]),
    .reached_o     (thr2_reached),
    .at_or_above_o (thr2_q),
    .cross_o       (thr2_cross)
  );

  // Log order: hot, external, critical, thr1, thr2, power limit
  assign log_set = {plim_now, thr2_reached, thr1_reached,
                    crit_now, ext_now, hot_now};

  // Only a written zero clears; a written one leaves the log alone
  assign log_clr = {6{msr_wr_i.status_wr}} &
                   ~{msr_wr_i.wdata[`CTS_ST_PLIM_LOG],
                     msr_wr_i.wdata[`CTS_ST_THR2_LOG],
                     msr_wr_i.wdata[`CTS_ST_THR1_LOG],
                     msr_wr_i.wdata[`CTS_ST_CRIT_LOG],
                     msr_wr_i.wdata[`CTS_ST_EXT_LOG],
                     msr_wr_i.wdata[`CTS_ST_HOT_LOG]};

  cts_sticky_log #(
    .N (`CTS_LOG_N)
  ) u_logs (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (log_set),
    .clr_i     (log_clr),
    .log_o     (log_q)
  );

  // Each pin keeps its own previous level so one cannot mask the other
  assign ext_hot_prev = st.ext_ack;
  assign fpr_prev     = st.fpr;

  // Interrupt causes, each gated by its own enable
  always_comb begin
    cause    = 8'h00;
    cause[0] = hot_now & ~st.hot & st.ctl[`CTS_CTL_HI_EN];
    cause[1] = ~hot_now & st.hot & st.ctl[`CTS_CTL_LO_EN];
    cause[2] = ext_hot_ack & ~ext_hot_prev &
               st.ctl[`CTS_CTL_EXT_EN];
    cause[3] = fpr_now & ~fpr_prev & st.ctl[`CTS_CTL_FPR_EN];
    cause[4] = crit_now & ~st.crit & st.ctl[`CTS_CTL_CRIT_EN];
    cause[5] = thr1_cross & st.ctl[`CTS_CTL_THR1_EN];
    cause[6] = thr2_cross & st.ctl[`CTS_CTL_THR2_EN];
    cause[7] = plim_now & ~st.plim & st.ctl[`CTS_CTL_PLN_EN];
  end

  always_comb begin
    next_st         = st;
    next_st.hot     = hot_now;
    next_st.ext     = ext_now;
    next_st.crit    = crit_now;
    next_st.plim    = plim_now;
    next_st.valid   = sensor_i.valid;
    next_st.ext_ack = ext_hot_ack;
    next_st.fpr     = fpr_now;
    // Readout only refreshed while valid, stale value kept otherwise
    if (sensor_i.valid) begin
      next_st.readout = sensor_i.readout;
    end
    // Unimplemented control bits stay zero
    if (msr_wr_i.ctl_wr) begin
      next_st.ctl = msr_wr_i.wdata & `CTS_CTL_WMASK;
    end
    next_st.cause = cause;
    next_st.irq   = |cause;
    next_st.pnote = cause[7];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st     <= '0;
      st.ctl <= `CTS_CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Status word is pure wiring of flip-flops and the RES_DEG field; reserved bits read zero
  always_comb begin
    therm_status_o                     = 64'h0;
    therm_status_o[`CTS_ST_HOT]        = st.hot;
    therm_status_o[`CTS_ST_HOT_LOG]    = log_q[0];
    therm_status_o[`CTS_ST_EXT]        = st.ext;
    therm_status_o[`CTS_ST_EXT_LOG]    = log_q[1];
    therm_status_o[`CTS_ST_CRIT]       = st.crit;
    therm_status_o[`CTS_ST_CRIT_LOG]   = log_q[2];
    therm_status_o[`CTS_ST_THR1]       = thr1_q;
    therm_status_o[`CTS_ST_THR1_LOG]   = log_q[3];
    therm_status_o[`CTS_ST_THR2]       = thr2_q;
    therm_status_o[`CTS_ST_THR2_LOG]   = log_q[4];
    therm_status_o[`CTS_ST_PLIM]       = st.plim;
    therm_status_o[`CTS_ST_PLIM_LOG]   = log_q[5];
    therm_status_o[`CTS_ST_RDOUT_MSB:`CTS_ST_RDOUT_LSB] = st.readout;
    therm_status_o[`CTS_ST_RES_MSB:`CTS_ST_RES_LSB] = RES_DEG;
    therm_status_o[`CTS_ST_VALID]      = st.valid;
  end

  assign therm_irq_ctl_o = st.ctl;
  assign thermal_irq_o   = st.irq;
  assign power_note_o    = st.pnote;
  assign irq_cause_o     = st.cause;

endmodule : cts_core_thermal

`default_nettype wire

// [bench/cts_thermal_assertions.sv]
// Port-level assertions for the core thermal block
`include "cts_thermal_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cts_thermal_checker
  import cts_pkg::*;
#(
  parameter logic [3:0] RES_DEG = `CTS_RES_DEFAULT
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire cts_sensor_t sensor_i,
  input wire cts_msr_wr_t msr_wr_i,
  input wire logic [63:0] therm_status_o,
  input wire logic [63:0] therm_irq_ctl_o,
  input wire logic        thermal_irq_o,
  input wire logic        power_note_o,
  input wire logic [7:0]  irq_cause_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_hot_live: assert property (1'h1 |=>
    therm_status_o[0] == $past(sensor_i.hot)) else $error("hot status");
  a_hot_log_hold: assert property (therm_status_o[1] &&
    !(msr_wr_i.status_wr && !msr_wr_i.wdata[1]) |=> therm_status_o[1])
    else $error("hot log lost");
  a_ext_live: assert property (1'h1 |=> therm_status_o[2] ==
    $past((!sensor_i.ext_hot_n && sensor_i.bidir_en) || !sensor_i.fpr_n))
    else $error("ext status");
  a_crit_logged: assert property (sensor_i.crit |=>
    therm_status_o[5:4] == 2'h3) else $error("crit status");
  a_thr1_status: assert property (1'h1 |=> therm_status_o[6] ==
    $past(sensor_i.valid && sensor_i.readout <= therm_irq_ctl_o[14:8]))
    else $error("thr1 status");
  a_plim_logged: assert property (sensor_i.below_req |=>
    therm_status_o[11:10] == 2'h3) else $error("plim status");
  a_log_clear: assert property (msr_wr_i.status_wr &&
    !msr_wr_i.wdata[11] && !sensor_i.below_req |=> !therm_status_o[11])
    else $error("plim log clear");
  a_valid_rdout: assert property (sensor_i.valid |=>
    therm_status_o[31] && therm_status_o[22:16] == $past(sensor_i.readout))
    else $error("readout");
  a_res_field: assert property (therm_status_o[30:27] == RES_DEG)
    else $error("resolution");
  a_hot_irq: assert property (sensor_i.hot && !therm_status_o[0] &&
    therm_irq_ctl_o[0] |=> thermal_irq_o && irq_cause_o[0])
    else $error("hot irq");
  a_pnote_gate: assert property (1'h1 |=> power_note_o ==
    $past(sensor_i.below_req && !therm_status_o[10] && therm_irq_ctl_o[24]))
    else $error("power note");
  a_ctl_write: assert property (msr_wr_i.ctl_wr |=>
    therm_irq_ctl_o == ($past(msr_wr_i.wdata) & `CTS_CTL_WMASK))
    else $error("ctl write");
endmodule : cts_thermal_checker

bind cts_core_thermal cts_thermal_checker #(.RES_DEG(RES_DEG)) chk_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sensor_i(sensor_i),
  .msr_wr_i(msr_wr_i), .therm_status_o(therm_status_o),
  .therm_irq_ctl_o(therm_irq_ctl_o), .thermal_irq_o(thermal_irq_o),
  .power_note_o(power_note_o), .irq_cause_o(irq_cause_o));
`default_nettype wire

// [bench/cts_platform_agent.sv]
// Sensor and platform agent that drives the block's sensor input
`timescale 1ns/100ps
`default_nettype none

module cts_platform_agent
  import cts_pkg::*;
(
  output var cts_sensor_t sensor_o
);
  initial sensor_o = {7'h1D, 7'h1E};

  task automatic step;
    logic [15:0] r;
    r = 16'($urandom);
    sensor_o.hot ^= r[0] & r[1];
    sensor_o.crit ^= r[2] & r[3] & r[4];
    sensor_o.below_req ^= r[5] & r[6];
    sensor_o.valid ^= r[7] & r[8] & r[9];
    if (r[10]) sensor_o.readout = 7'($urandom_range(24, 39));
    // Bidir moves only while the hot pin is idle, so gated edges stay clean
    sensor_o.bidir_en ^= r[11] & r[12] & sensor_o.ext_hot_n;
    // One pin at a time, always through idle
    if (!sensor_o.ext_hot_n || !sensor_o.fpr_n) begin
      if (r[13]) {sensor_o.ext_hot_n, sensor_o.fpr_n} = 2'h3;
    end else if (r[13] & r[15])
      {sensor_o.ext_hot_n, sensor_o.fpr_n} = r[14] ? 2'h1 : 2'h2;
  endtask : step
endmodule : cts_platform_agent
`default_nettype wire

// [bench/testbench.sv]
// Random traffic against a behavioural model of the thermal block
`include "cts_thermal_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import cts_pkg::*;
  localparam logic [3:0] RES = 4'h5;
  logic        sys_clk_i;
  logic        rst_i;
  cts_sensor_t sensor;
  cts_msr_wr_t msr_wr;
  logic [63:0] st_o, ctl_o, m_st, m_ctl;
  logic        irq_o, pn_o;
  logic [7:0]  cause_o, m_cause;
  logic [5:0]  m_log;
  logic [6:0]  m_rd;
  logic [8:0]  p;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  cts_core_thermal #(.RES_DEG(RES)) cts_core_thermal_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sensor_i(sensor),
    .msr_wr_i(msr_wr), .therm_status_o(st_o), .therm_irq_ctl_o(ctl_o),
    .thermal_irq_o(irq_o), .power_note_o(pn_o), .irq_cause_o(cause_o));
  cts_platform_agent cts_platform_agent_i (.sensor_o(sensor));

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    sys_clk_i = 1'h0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Model: p holds last levels
  // {fpr, hot pin, valid, plim, thr2, thr1, crit, ext, hot}
  always @(posedge sys_clk_i or posedge rst_i) begin
    logic e, t1, t2;
    if (rst_i) begin
      {m_ctl, m_log, m_rd, m_cause, p} = '0;
      m_st = 64'(RES) << 27;
    end else begin
      e = (!sensor.ext_hot_n && sensor.bidir_en) || !sensor.fpr_n;
      t1 = sensor.valid && sensor.readout <= m_ctl[14:8];
      t2 = sensor.valid && sensor.readout <= m_ctl[22:16];
      m_cause = {sensor.below_req & !p[5] & m_ctl[24],
        (t2 ^ p[4]) & m_ctl[23], (t1 ^ p[3]) & m_ctl[15],
        sensor.crit & !p[2] & m_ctl[4],
        !sensor.fpr_n & !p[8] & m_ctl[3],
        !sensor.ext_hot_n & sensor.bidir_en & !p[7] & m_ctl[2],
        !sensor.hot & p[0] & m_ctl[1], sensor.hot & !p[0] & m_ctl[0]};
      p = {!sensor.fpr_n, !sensor.ext_hot_n && sensor.bidir_en,
        sensor.valid, sensor.below_req, t2, t1, sensor.crit, e, sensor.hot};
      if (msr_wr.status_wr)
        m_log &= {msr_wr.wdata[11], msr_wr.wdata[9], msr_wr.wdata[7],
          msr_wr.wdata[5], msr_wr.wdata[3], msr_wr.wdata[1]};
      m_log |= p[5:0];
      if (msr_wr.ctl_wr) m_ctl = msr_wr.wdata & `CTS_CTL_WMASK;
      if (sensor.valid) m_rd = sensor.readout;
      for (int i = 0; i < 6; i++) m_st[2*i +: 2] = {m_log[i], p[i]};
      m_st[22:16] = m_rd;
      m_st[31] = p[6];
    end
  end

  always @(negedge sys_clk_i) begin
    if (cycles > 0) begin
      chk("status", st_o, m_st);
      chk("control", ctl_o, m_ctl);
      chk("cause", 64'(cause_o), 64'(m_cause));
      chk("pulse", 64'({pn_o, irq_o}), 64'({m_cause[7], |m_cause}));
    end
  end

  // Ceiling well above the 3000 cycles of traffic
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    int op;
    logic [63:0] w;
    void'($urandom(32'h4B68));
    rst_i = 1'h1;
    msr_wr = '0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_i);
      #2 rst_i = (i < 16) || (i >= 1500 && i < 1503);
      // Writes never share a cycle with sensor moves; none during reset
      op = rst_i ? 2 : $urandom_range(0, 9);
      w = {$urandom, $urandom};
      w[14:8] = 7'($urandom_range(24, 39));
      w[22:16] = 7'($urandom_range(24, 39));
      // New thresholds kept clear of the readout so crossings do not chatter
      if (7'(w[14:8] - sensor.readout + RES) <= 7'(2 * RES))
        w[14:8] = 7'(sensor.readout + RES + 1);
      if (7'(w[22:16] - sensor.readout + RES) <= 7'(2 * RES))
        w[22:16] = 7'(sensor.readout + RES + 1);
      msr_wr = '{status_wr: op == 1, ctl_wr: op == 0, wdata: w};
      if (op > 1) cts_platform_agent_i.step();
    end
    @(posedge sys_clk_i);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
